// >>> dpp_pkg.sv
package dpp_pkg;

  // --------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------
  localparam logic [19:0] OFS_LINE_RANGE_COMPARE = 20'h7_0004;
  localparam logic [19:0] OFS_PIXEL_PIPE_CONFIG = 20'h7_0008;
  localparam logic [19:0] OFS_BLIT_CONTROL = 20'h7_000c;
  localparam logic [19:0] OFS_RESERVED_SLOT = 20'h7_0010;
  localparam logic [19:0] OFS_SCRATCH_FLAGS_ONE = 20'h7_0014;
  localparam logic [19:0] OFS_SCRATCH_FLAGS_TWO = 20'h7_0018;
  localparam logic [19:0] OFS_SCRATCH_FLAGS_THREE = 20'h7_001c;
  localparam logic [19:0] OFS_FRAME_BASE_ADDRESS = 20'h7_0020;
  localparam logic [19:0] OFS_DISPLAY_EVENT_SELECT = 20'h7_0024;

  // --------------------------------------------------------------
  // writable bit masks and reset values
  // --------------------------------------------------------------
  localparam logic [31:0] MSK_LINE_RANGE = 32'h8fff_0fff;
  localparam logic [31:0] MSK_PIXEL_PIPE = 32'h0c1f_9d03;
  localparam logic [31:0] MSK_FRAME_BASE = 32'h03ff_fff8;
  localparam logic [31:0] MSK_EVENT_ENABLE = 32'h0703_0000;
  localparam logic [31:0] MSK_EVENT_STATUS = 32'h0000_0703;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int SLC_INCL_BIT = 31;
  localparam int SLC_TOP_LSB = 16;
  localparam int SLC_BOT_LSB = 0;
  localparam int PPC_GFX_GAMMA = 27;
  localparam int PPC_OVL_GAMMA = 26;
  localparam int PPC_CRT_NODELAY = 20;
  localparam int PPC_CMODE_LSB = 16;
  localparam int PPC_DAC8 = 15;
  localparam int PPC_CURSOR_EN = 12;
  localparam int PPC_EXT_STATUS = 11;
  localparam int PPC_OVERSCAN = 10;
  localparam int PPC_PAL_ADDR = 8;
  localparam int PPC_NO_WRAP = 1;
  localparam int PPC_HIRES = 0;
  localparam int BLT_EXPAND_LSB = 4;
  localparam int BLT_BUSY_BIT = 0;
  localparam int EVS_OVL_UPD = 0;
  localparam int EVS_VBLANK = 1;
  localparam int EVS_LINE_CMP = 8;
  localparam int EVS_VSYNC = 9;
  localparam int EVS_HOTPLUG = 10;
  localparam int EVS_HOTPLUG_PIN = 15;
  localparam int EVS_EN_OFS = 16;

  // --------------------------------------------------------------
  // encodings
  // --------------------------------------------------------------
  localparam logic [3:0] CM_VGA = 4'h0;
  localparam logic [3:0] CM_PACK8 = 4'h2;
  localparam logic [3:0] CM_RGB555 = 4'h4;
  localparam logic [3:0] CM_RGB565 = 4'h5;
  localparam logic [3:0] CM_RGB24C = 4'h6;
  localparam logic [3:0] CM_RGB24U = 4'h7;
  localparam logic [3:0] BYTES_ALL = 4'hf;
  localparam logic [3:0] BYTES_LOW3 = 4'h7;

  typedef enum logic [2:0] {
    DPP_FMT_VGA, DPP_FMT_PACK8, DPP_FMT_RGB555, DPP_FMT_RGB565,
    DPP_FMT_RGB24C, DPP_FMT_RGB24U, DPP_FMT_RSVD
  } dpp_fmt_t;

  typedef enum logic [1:0] {
    DPP_EXP_8BPP, DPP_EXP_16BPP, DPP_EXP_24BPP, DPP_EXP_RSVD
  } dpp_exp_t;

endpackage

// >>> dpp_regs.sv
`timescale 1ns/1ns
module dpp_regs #(
  parameter int LINE_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [19:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [LINE_W-1:0] disp_line,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic vblank,
  input wire logic ovl_updated,
  input wire logic hotplug_n,
  input wire logic blit_busy,
  input wire logic [7:0] red_hold,
  input wire logic [7:0] green_hold,
  input wire logic [5:0] dac_fsm_status,
  input wire logic [7:0] palette_mask_port_reg,
  input wire logic [7:0] palette_write_index_port_reg,
  input wire logic [7:0] palette_state_port_reg,
  output logic [7:0] palette_mask_port_rd,
  output logic [7:0] palette_write_index_port_rd,
  output logic [7:0] palette_state_port_rd,
  output logic line_match,
  output logic gfx_via_palette,
  output logic ovl_via_palette,
  output logic crt_ctrl_delay,
  output dpp_pkg::dpp_fmt_t pixel_fmt,
  output logic [3:0] pixel_byte_en,
  output logic dac_8bit,
  output logic cursor_en,
  output logic ext_status_rd,
  output logic overscan_en,
  output logic ext_palette_en,
  output logic vga_wrap_en,
  output logic hires_mode,
  output dpp_pkg::dpp_exp_t expand_depth,
  output logic [22:0] frame_base_active,
  output logic vblank_event,
  output logic display_event
);

  // --------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------
  if (LINE_W != 12) begin : g_bad_width
    $error("dpp_regs: LINE_W must be 12");
  end

  localparam int TOP_END = dpp_pkg::SLC_TOP_LSB + LINE_W;
  localparam int BOT_END = dpp_pkg::SLC_BOT_LSB + LINE_W;
  if (TOP_END > dpp_pkg::SLC_INCL_BIT) begin : g_bad_top
    $error("dpp_regs: top limit runs into the inclusive bit");
  end
  if (BOT_END > dpp_pkg::SLC_TOP_LSB) begin : g_bad_bot
    $error("dpp_regs: bottom limit runs into the top limit");
  end
  if (dpp_pkg::EVS_EN_OFS != 16) begin : g_bad_en
    $error("dpp_regs: event enables must sit in the upper half");
  end
  if (dpp_pkg::BLT_EXPAND_LSB + 2 > 16) begin : g_bad_exp
    $error("dpp_regs: expansion field outside blit control");
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [31:0] scan_line_compare;
    logic [31:0] ppc;
    logic [1:0] blt_exp;
    logic [2:0][31:0] scratch_flags;
    logic [31:0] base_stage;
    logic [31:0] base_act;
    logic [31:0] evs;
    logic [LINE_W-1:0] line_q;
    logic hs_q;
    logic vs_q;
    logic vb_q;
    logic hp_q;
    logic cmp_q;
    logic [31:0] rdata;
    logic rvalid;
    logic [7:0] mask_rd;
    logic [7:0] wx_rd;
    logic [7:0] state_rd;
    logic gfx_pal;
    logic ovl_pal;
    logic crt_dly;
    dpp_pkg::dpp_fmt_t fmt;
    logic [3:0] byte_en;
    logic dac8;
    logic cur_en;
    logic ext_rd;
    logic ovs_en;
    logic pal_en;
    logic wrap_en;
    logic hires;
    dpp_pkg::dpp_exp_t exp;
    logic vb_ev;
    logic disp_ev;
  } dpp_state_t;

  dpp_state_t st_ff;
  dpp_state_t nxt_st;

  // byte-lane merge of a write into a register, limited to its mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be,
                                        input logic [31:0] msk);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
    return (old & ~lanes) | (wd & lanes);
  endfunction

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic wr_slc;
    logic wr_ppc;
    logic wr_blt;
    logic wr_base;
    logic wr_evs;
    logic [2:0] wr_swf;
    logic in_range;
    logic cmp;
    logic vs_rise;
    logic [31:0] ev_set;
    logic [31:0] ev_clr;
    logic [31:0] rd;
    logic [31:0] ev_live;
    wr_slc = bus_wr && bus_addr == dpp_pkg::OFS_LINE_RANGE_COMPARE;
    wr_ppc = bus_wr && bus_addr == dpp_pkg::OFS_PIXEL_PIPE_CONFIG;
    wr_blt = bus_wr && bus_addr == dpp_pkg::OFS_BLIT_CONTROL;
    wr_base = bus_wr && bus_addr == dpp_pkg::OFS_FRAME_BASE_ADDRESS;
    wr_evs = bus_wr && bus_addr == dpp_pkg::OFS_DISPLAY_EVENT_SELECT;
    wr_swf[0] = bus_wr && bus_addr == dpp_pkg::OFS_SCRATCH_FLAGS_ONE;
    wr_swf[1] = bus_wr && bus_addr == dpp_pkg::OFS_SCRATCH_FLAGS_TWO;
    wr_swf[2] = bus_wr && bus_addr == dpp_pkg::OFS_SCRATCH_FLAGS_THREE;
    nxt_st = st_ff;

    // ------------------------------------------------------------
    // register writes; reserved bits masked off
    // ------------------------------------------------------------
    if (wr_slc) begin
      nxt_st.scan_line_compare = merge(st_ff.scan_line_compare, bus_wdata, bus_be,
                         dpp_pkg::MSK_LINE_RANGE);
    end
    if (wr_ppc) begin
      nxt_st.ppc = merge(st_ff.ppc, bus_wdata, bus_be,
                         dpp_pkg::MSK_PIXEL_PIPE);
    end
    if (wr_blt && bus_be[0]) begin
      nxt_st.blt_exp = bus_wdata[dpp_pkg::BLT_EXPAND_LSB +: 2];
    end
    for (int i = 0; i < 3; i++) begin
      if (wr_swf[i]) begin
        nxt_st.scratch_flags[i] = merge(st_ff.scratch_flags[i], bus_wdata, bus_be,
                              32'hffff_ffff);
      end
    end
    if (wr_base) begin
      nxt_st.base_stage = merge(st_ff.base_stage, bus_wdata, bus_be,
                                dpp_pkg::MSK_FRAME_BASE);
    end

    // ------------------------------------------------------------
    // sampled display signals
    // ------------------------------------------------------------
    nxt_st.hs_q = hsync;
    nxt_st.vs_q = vsync;
    nxt_st.vb_q = vblank;
    nxt_st.hp_q = hotplug_n;
    if (hsync && !st_ff.hs_q) begin
      nxt_st.line_q = disp_line;
    end
    vs_rise = vsync && !st_ff.vs_q;
    if (vs_rise) begin
      nxt_st.base_act = nxt_st.base_stage;
    end

    // ------------------------------------------------------------
    // line range compare
    // ------------------------------------------------------------
    in_range = st_ff.line_q <= st_ff.scan_line_compare[dpp_pkg::SLC_TOP_LSB +: LINE_W]
      && st_ff.line_q >= st_ff.scan_line_compare[dpp_pkg::SLC_BOT_LSB +: LINE_W];
    cmp = st_ff.scan_line_compare[dpp_pkg::SLC_INCL_BIT] ? in_range : !in_range;
    nxt_st.cmp_q = cmp;

    // ------------------------------------------------------------
    // event capture: enabled events set, write 1 clears, set wins
    // ------------------------------------------------------------
    ev_set = '0;
    ev_set[dpp_pkg::EVS_OVL_UPD] = ovl_updated && vblank;
    ev_set[dpp_pkg::EVS_VBLANK] = vblank && !st_ff.vb_q;
    ev_set[dpp_pkg::EVS_LINE_CMP] = cmp && !st_ff.cmp_q;
    ev_set[dpp_pkg::EVS_VSYNC] = vs_rise;
    ev_set[dpp_pkg::EVS_HOTPLUG] = !hotplug_n && st_ff.hp_q;
    ev_set = ev_set & (st_ff.evs >> dpp_pkg::EVS_EN_OFS)
      & dpp_pkg::MSK_EVENT_STATUS;
    ev_clr = '0;
    if (wr_evs) begin
      ev_clr = merge('0, bus_wdata, bus_be,
                     dpp_pkg::MSK_EVENT_STATUS);
      nxt_st.evs = merge(st_ff.evs, bus_wdata, bus_be,
                         dpp_pkg::MSK_EVENT_ENABLE);
    end
    nxt_st.evs = (nxt_st.evs & ~ev_clr) | ev_set;
    ev_live = st_ff.evs & (st_ff.evs >> dpp_pkg::EVS_EN_OFS);
    nxt_st.vb_ev = ev_live[dpp_pkg::EVS_OVL_UPD]
      | ev_live[dpp_pkg::EVS_VBLANK];
    nxt_st.disp_ev = ev_live[dpp_pkg::EVS_LINE_CMP]
      | ev_live[dpp_pkg::EVS_VSYNC]
      | ev_live[dpp_pkg::EVS_HOTPLUG];

    // ------------------------------------------------------------
    // read mux; unmapped and reserved locations read zero
    // ------------------------------------------------------------
    rd = dpp_pkg::RST_WORD;
    unique case (bus_addr)
      dpp_pkg::OFS_LINE_RANGE_COMPARE: rd = st_ff.scan_line_compare;
      dpp_pkg::OFS_PIXEL_PIPE_CONFIG: rd = st_ff.ppc;
      dpp_pkg::OFS_BLIT_CONTROL: begin
        rd[dpp_pkg::BLT_EXPAND_LSB +: 2] = st_ff.blt_exp;
        rd[dpp_pkg::BLT_BUSY_BIT] = blit_busy;
      end
      dpp_pkg::OFS_SCRATCH_FLAGS_ONE: rd = st_ff.scratch_flags[0];
      dpp_pkg::OFS_SCRATCH_FLAGS_TWO: rd = st_ff.scratch_flags[1];
      dpp_pkg::OFS_SCRATCH_FLAGS_THREE: rd = st_ff.scratch_flags[2];
      dpp_pkg::OFS_FRAME_BASE_ADDRESS: rd = st_ff.base_act;
      dpp_pkg::OFS_DISPLAY_EVENT_SELECT: begin
        rd = st_ff.evs;
        rd[dpp_pkg::EVS_HOTPLUG_PIN] = st_ff.hp_q;
      end
      default: rd = dpp_pkg::RST_WORD;
    endcase
    nxt_st.rvalid = bus_rd;
    nxt_st.rdata = bus_rd ? rd : dpp_pkg::RST_WORD;

    // ------------------------------------------------------------
    // palette port read redirection
    // ------------------------------------------------------------
    if (st_ff.ppc[dpp_pkg::PPC_EXT_STATUS]) begin
      nxt_st.mask_rd = red_hold;
      nxt_st.wx_rd = green_hold;
      nxt_st.state_rd = {dac_fsm_status, palette_state_port_reg[1:0]};
    end else begin
      nxt_st.mask_rd = palette_mask_port_reg;
      nxt_st.wx_rd = palette_write_index_port_reg;
      nxt_st.state_rd = palette_state_port_reg;
    end

    // ------------------------------------------------------------
    // pipeline controls
    // ------------------------------------------------------------
    nxt_st.gfx_pal = st_ff.ppc[dpp_pkg::PPC_GFX_GAMMA];
    nxt_st.ovl_pal = st_ff.ppc[dpp_pkg::PPC_OVL_GAMMA];
    nxt_st.crt_dly = !st_ff.ppc[dpp_pkg::PPC_CRT_NODELAY];
    nxt_st.dac8 = st_ff.ppc[dpp_pkg::PPC_DAC8];
    nxt_st.cur_en = st_ff.ppc[dpp_pkg::PPC_CURSOR_EN];
    nxt_st.ext_rd = st_ff.ppc[dpp_pkg::PPC_EXT_STATUS];
    nxt_st.ovs_en = st_ff.ppc[dpp_pkg::PPC_OVERSCAN];
    nxt_st.pal_en = st_ff.ppc[dpp_pkg::PPC_PAL_ADDR];
    nxt_st.wrap_en = !st_ff.ppc[dpp_pkg::PPC_NO_WRAP];
    nxt_st.hires = st_ff.ppc[dpp_pkg::PPC_HIRES];
    nxt_st.byte_en = dpp_pkg::BYTES_ALL;
    unique case (st_ff.ppc[dpp_pkg::PPC_CMODE_LSB +: 4])
      dpp_pkg::CM_VGA: nxt_st.fmt = dpp_pkg::DPP_FMT_VGA;
      dpp_pkg::CM_PACK8: nxt_st.fmt = dpp_pkg::DPP_FMT_PACK8;
      dpp_pkg::CM_RGB555: nxt_st.fmt = dpp_pkg::DPP_FMT_RGB555;
      dpp_pkg::CM_RGB565: nxt_st.fmt = dpp_pkg::DPP_FMT_RGB565;
      dpp_pkg::CM_RGB24C: nxt_st.fmt = dpp_pkg::DPP_FMT_RGB24C;
      dpp_pkg::CM_RGB24U: begin
        nxt_st.fmt = dpp_pkg::DPP_FMT_RGB24U;
        nxt_st.byte_en = dpp_pkg::BYTES_LOW3;
      end
      default: nxt_st.fmt = dpp_pkg::DPP_FMT_RSVD;
    endcase
    nxt_st.exp = dpp_pkg::dpp_exp_t'(st_ff.blt_exp);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign bus_rdata = st_ff.rdata;
  assign bus_rvalid = st_ff.rvalid;
  assign palette_mask_port_rd = st_ff.mask_rd;
  assign palette_write_index_port_rd = st_ff.wx_rd;
  assign palette_state_port_rd = st_ff.state_rd;
  assign line_match = st_ff.cmp_q;
  assign gfx_via_palette = st_ff.gfx_pal;
  assign ovl_via_palette = st_ff.ovl_pal;
  assign crt_ctrl_delay = st_ff.crt_dly;
  assign pixel_fmt = st_ff.fmt;
  assign pixel_byte_en = st_ff.byte_en;
  assign dac_8bit = st_ff.dac8;
  assign cursor_en = st_ff.cur_en;
  assign ext_status_rd = st_ff.ext_rd;
  assign overscan_en = st_ff.ovs_en;
  assign ext_palette_en = st_ff.pal_en;
  assign vga_wrap_en = st_ff.wrap_en;
  assign hires_mode = st_ff.hires;
  assign expand_depth = st_ff.exp;
  assign frame_base_active = st_ff.base_act[25:3];
  assign vblank_event = st_ff.vb_ev;
  assign display_event = st_ff.disp_ev;

endmodule

// >>> dpp_regs_monitor.sv
`timescale 1ns/1ns
module dpp_regs_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [19:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic vsync,
  input wire logic blit_busy,
  input wire logic gfx_via_palette,
  input wire logic dac_8bit,
  input wire logic vga_wrap_en,
  input wire logic [3:0] pixel_byte_en,
  input dpp_pkg::dpp_fmt_t pixel_fmt,
  input dpp_pkg::dpp_exp_t expand_depth,
  input wire logic [22:0] frame_base_active
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  wire pw = bus_wr && bus_addr == dpp_pkg::OFS_PIXEL_PIPE_CONFIG;
  wire bw = bus_wr && bus_addr == dpp_pkg::OFS_BLIT_CONTROL;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_RVALID: assert property (bus_rvalid == $past(bus_rd))
    else $error("read answer not one cycle after request");
  AST_RSVD_ZERO: assert property (bus_rd &&
    bus_addr == dpp_pkg::OFS_RESERVED_SLOT |=> bus_rdata == '0)
    else $error("reserved slot read nonzero");
  AST_BUSY_BIT: assert property (bus_rd &&
    bus_addr == dpp_pkg::OFS_BLIT_CONTROL |=>
    bus_rdata[0] == $past(blit_busy))
    else $error("busy bit does not follow engine");
  AST_GFX_GAMMA: assert property (pw && bus_be[3] |->
    ##2 gfx_via_palette == $past(bus_wdata[27], 2))
    else $error("graphics palette path wrong");
  AST_DAC8: assert property (pw && bus_be[1] |->
    ##2 dac_8bit == $past(bus_wdata[15], 2))
    else $error("dac width wrong");
  AST_WRAP: assert property (pw && bus_be[0] |->
    ##2 vga_wrap_en == !$past(bus_wdata[1], 2))
    else $error("wrap enable wrong");
  AST_FMT24U: assert property ((pixel_fmt == dpp_pkg::DPP_FMT_RGB24U) ==
    (pixel_byte_en == dpp_pkg::BYTES_LOW3))
    else $error("byte lanes disagree with pixel format");
  AST_EXPAND: assert property (bw && bus_be[0] |->
    ##2 expand_depth == $past(bus_wdata[5:4], 2))
    else $error("expansion depth wrong");
  AST_BASE_VSYNC: assert property ($changed(frame_base_active) |->
    $past(vsync) && !$past(vsync, 2))
    else $error("base changed without vsync rise");
  cover property (pw ##2 dac_8bit);
  cover property ($rose(vsync) ##2 $changed(frame_base_active));
  cover property (bus_rvalid && bus_rdata != '0);
endmodule
bind dpp_regs dpp_regs_monitor u_mon (.clk_sys, .rst, .bus_addr, .bus_wr,
  .bus_rd, .bus_be, .bus_wdata, .bus_rdata, .bus_rvalid, .vsync,
  .blit_busy, .gfx_via_palette, .dac_8bit, .vga_wrap_en, .pixel_byte_en,
  .pixel_fmt, .expand_depth, .frame_base_active);

// >>> display_pixel_pipe_regs_tb.sv
`timescale 1ns/1ns
module display_pixel_pipe_regs_tb;
  logic clk_sys = 0, rst = 1, bus_wr = 0, bus_rd = 0, bus_rvalid;
  logic hsync = 0, vsync = 0, vblank = 0, hotplug_n = 1, blit_busy = 0;
  logic ovl_upd = 0;
  logic [19:0] bus_addr = '0;
  logic [3:0] bus_be = '0, pbe;
  logic [31:0] bus_wdata = '0, bus_rdata, d, seed = 32'h0000_004d;
  logic [11:0] disp_line = '0;
  logic [7:0] rh = '0, gh = '0, pm = '0, pwx = '0, pst = '0;
  logic [7:0] pmr, pwr, psr;
  logic [5:0] dfs = '0;
  logic lm, gfx, ovl, crt, dac8, cur, ext, ovs, epal, wrap, hires, vbe, dse;
  logic [22:0] fba;
  dpp_pkg::dpp_fmt_t fmt;
  dpp_pkg::dpp_exp_t xd;
  logic [31:0] exp_q[$];
  int error_cnt = 0, n_tests = 0, cyc = 0, e;

  dpp_regs uut (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .disp_line(disp_line), .hsync(hsync), .vsync(vsync), .vblank(vblank),
    .ovl_updated(ovl_upd), .hotplug_n(hotplug_n), .blit_busy(blit_busy),
    .red_hold(rh), .green_hold(gh), .dac_fsm_status(dfs),
    .palette_mask_port_reg(pm), .palette_write_index_port_reg(pwx),
    .palette_state_port_reg(pst), .palette_mask_port_rd(pmr),
    .palette_write_index_port_rd(pwr), .palette_state_port_rd(psr),
    .line_match(lm), .gfx_via_palette(gfx), .ovl_via_palette(ovl),
    .crt_ctrl_delay(crt), .pixel_fmt(fmt), .pixel_byte_en(pbe),
    .dac_8bit(dac8), .cursor_en(cur), .ext_status_rd(ext),
    .overscan_en(ovs), .ext_palette_en(epal), .vga_wrap_en(wrap),
    .hires_mode(hires), .expand_depth(xd), .frame_base_active(fba),
    .vblank_event(vbe), .display_event(dse));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [19:0] a, input logic [3:0] be,
                    input logic [31:0] v);
    @(negedge clk_sys);
    bus_wr = 1;
    bus_addr = a;
    bus_be = be;
    bus_wdata = v;
    @(negedge clk_sys);
    bus_wr = 0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] v);
    @(negedge clk_sys);
    bus_rd = 1;
    bus_addr = a;
    exp_q.push_back(v);
    @(negedge clk_sys);
    bus_rd = 0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1;
    @(negedge clk_sys);
    s = 0;
    tick(2);
  endtask
  always @(negedge clk_sys) begin
    if (bus_rvalid === 1'b1) chk(bus_rdata, exp_q.pop_front());
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    tick(5);
    rst = 0;
    {rh, gh, pm, pwx} = rnd();
    {pst, dfs} = 14'(rnd());
    for (int i = 0; i < 9; i++) rd(20'h7_0000 + 20'(i * 4), '0);
    rd(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 32'h0000_8000);
    chk(32'({crt, wrap, pbe}), 32'h0000_003f);
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      wr(20'h7_0014 + 20'(i * 4), 4'h5, d);
      rd(20'h7_0014 + 20'(i * 4), d & 32'h00ff_00ff);
    end
    wr(dpp_pkg::OFS_RESERVED_SLOT, 4'hf, rnd());
    rd(dpp_pkg::OFS_RESERVED_SLOT, '0);
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      wr(dpp_pkg::OFS_PIXEL_PIPE_CONFIG, 4'hf, d);
      tick(2);
      rd(dpp_pkg::OFS_PIXEL_PIPE_CONFIG, d & dpp_pkg::MSK_PIXEL_PIPE);
      chk(32'({gfx, ovl, crt, dac8, cur}),
        32'({d[27], d[26], !d[20], d[15], d[12]}));
      chk(32'({ext, ovs, epal, wrap, hires}),
        32'({d[11], d[10], d[8], !d[1], d[0]}));
    end
    for (int m = 0; m < 16; m++) begin
      wr(dpp_pkg::OFS_PIXEL_PIPE_CONFIG, 4'h4, 32'(m << 16));
      tick(2);
      e = m == 0 ? 0 : m == 2 ? 1 : (m > 3 && m < 8) ? m - 2 : 6;
      chk(32'({fmt, pbe}), 32'({e[2:0], m == 7 ? 4'h7 : 4'hf}));
    end
    wr(dpp_pkg::OFS_PIXEL_PIPE_CONFIG, 4'h2, 32'h0000_0800);
    tick(3);
    chk({8'h00, pmr, pwr, psr}, {8'h00, rh, gh, dfs, pst[1:0]});
    wr(dpp_pkg::OFS_PIXEL_PIPE_CONFIG, 4'h2, 32'h0000_0000);
    tick(3);
    chk({8'h00, pmr, pwr, psr}, {8'h00, pm, pwx, pst});
    for (int i = 0; i < 4; i++) begin
      blit_busy = i[0];
      d = (rnd() & 32'hffff_ffcf) | 32'(i << 4);
      wr(dpp_pkg::OFS_BLIT_CONTROL, 4'hf, d);
      tick(2);
      rd(dpp_pkg::OFS_BLIT_CONTROL, 32'(i << 4) | 32'(i % 2));
      chk(32'(xd), 32'(i));
    end
    d = rnd();
    wr(dpp_pkg::OFS_FRAME_BASE_ADDRESS, 4'hf, d);
    rd(dpp_pkg::OFS_FRAME_BASE_ADDRESS, '0);
    pulse(vsync);
    rd(dpp_pkg::OFS_FRAME_BASE_ADDRESS, d & dpp_pkg::MSK_FRAME_BASE);
    chk(32'(fba), 32'(d[25:3]));
    for (int i = 0; i < 8; i++) begin
      wr(dpp_pkg::OFS_LINE_RANGE_COMPARE, 4'hf,
        {i[2], 3'h0, 12'h0c8, 4'h0, 12'h064});
      disp_line = (i % 4 < 2) ? 12'(99 + i % 2) : 12'(198 + i % 4);
      pulse(hsync);
      chk(32'(lm), 32'(i[2] == (disp_line >= 100 && disp_line <= 200)));
    end
    wr(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 4'hc, 32'h0202_0000);
    pulse(vsync);
    pulse(vblank);
    pulse(hotplug_n);
    hotplug_n = 0;
    tick(3);
    hotplug_n = 1;
    tick(3);
    chk(32'({vbe, dse}), 32'h0000_0003);
    rd(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 32'h0202_8202);
    wr(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 4'h2, 32'h0000_0202);
    tick(2);
    chk(32'({vbe, dse}), 32'h0000_0002);
    rd(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 32'h0202_8002);
    wr(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 4'h1, 32'h0000_0002);
    wr(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 4'h4, 32'h0001_0000);
    vblank = 1;
    ovl_upd = 1;
    tick(2);
    ovl_upd = 0;
    vblank = 0;
    tick(3);
    chk(32'({vbe, dse}), 32'h0000_0002);
    rd(dpp_pkg::OFS_DISPLAY_EVENT_SELECT, 32'h0201_8001);
    pulse(hsync);
    pulse(hsync);
    wr(dpp_pkg::OFS_PIXEL_PIPE_CONFIG, 4'h1, 32'h0000_0001);
    tick(2);
    chk(32'(hires), 32'h0000_0001);
    tick(3);
    chk(32'(exp_q.size()), '0);
    end_of_test();
  end
endmodule
